// [hw/seei_slave.sv]
// Purpose: two-wire slave front end of a small byte memory
// Assumes: link_clk samples the bus lines; sys_clk times write and power-up
// Notes: single byte write and immediate or continued read only
//
// Functional notes
// - reset holds logic until supply is valid
// - line only driven low, released for one
// - sample on rising edge, change after falling
// - data change while clock high is framing
// - start is sda fall, stop sda rise
// - ignore the bus until a start
// - top nibble must equal type code
// - next three bits compare pins or address
// - last address bit one reads, zero writes
// - acknowledge matching address on ninth clock
// - acknowledge address and data bytes when writing
// - read shifts eight bits, releases ninth clock
// - byte write sequence ends with master stop
// - stop after acked data starts write cycle
// - ignore bus while internal write runs
// - ready for commands within power-up delay
// - write protect high blocks every write
// - floating select and protect pins read low
// - suppress line glitches up to 100 ns
// - no ack during write cycle, ack after
// - protect sampled before first data byte
// - bare read uses current address pointer
`timescale 1ns/1ps
module seei_slave
  import seei_pkg::*;
#(
  parameter int unsigned WR_CYCLES = WR_CYC,
  parameter int unsigned PU_CYCLES = PU_CYC,
  parameter logic [2:0] CS_COMPARE = CS_COMPARE_DEF
)
(
  // system clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // link sampling clock
  input wire logic link_clk,
  // bus lines, data is open drain
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // static straps
  input wire logic chip_select_bit0,
  input wire logic chip_select_bit1,
  input wire logic chip_select_bit2,
  input wire logic wp,
  // status
  output logic write_busy,
  output logic dev_ready
);

  // system domain signals
  logic pu_busy;
  logic tog_s1;
  logic tog_s2;
  logic tog_s3;
  logic wr_start;

  // link domain signals
  logic lrst_s1;
  logic lrst_n;
  logic scl_f;
  logic sda_f;
  logic scl_d;
  logic sda_d;
  logic start_ev;
  logic stop_ev;
  logic scl_rise;
  logic scl_fall;
  logic busy_s1;
  logic busy_s2;
  logic ready_s1;
  logic ready_s2;
  logic [3:0] pins_s1;
  logic [3:0] pins_s2;
  logic [2:0] cs_s;
  logic wp_s;
  logic wr_wait;
  logic link_busy;
  seei_state_t state;
  seei_state_t nxt;
  logic [3:0] bitcnt;
  logic [7:0] shreg;
  logic [7:0] tx;
  logic [2:0] hi_bits;
  logic [MEM_ADDR_W-1:0] ptr;
  logic wp_lat;
  logic mack;
  logic wr_pend;
  logic [7:0] wr_data;
  logic wr_tog;
  logic commit;
  logic dev_match;
  logic [7:0] mem_rd;
  logic [7:0] mem [0:(1 << MEM_ADDR_W) - 1];

  // power-up delay runs out of reset; commands wait for it
  seei_timer #(
    .COUNT(PU_CYCLES),
    .RST_RUN(1'b1)
  ) u_pu_timer (
    .clk(sys_clk),
    .rst_n(resetn),
    .start(1'b0),
    .busy(pu_busy)
  );

  // write request toggle from the link domain
  always_ff @(posedge sys_clk)
  begin
    tog_s1 <= wr_tog;
    tog_s2 <= tog_s1;
    tog_s3 <= tog_s2;
  end

  assign wr_start = tog_s2 ^ tog_s3;

  // self-timed write cycle
  seei_timer #(
    .COUNT(WR_CYCLES),
    .RST_RUN(1'b0)
  ) u_wr_timer (
    .clk(sys_clk),
    .rst_n(resetn),
    .start(wr_start),
    .busy(write_busy)
  );

  // ready flag registered so the port comes from a flop
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      dev_ready <= 1'b0;
    else
      dev_ready <= ~pu_busy;
  end

  // reset carried into the link domain; brown-out resets it too
  always_ff @(posedge link_clk)
  begin
    lrst_s1 <= resetn;
    lrst_n <= lrst_s1;
  end

  // status levels from the system domain
  always_ff @(posedge link_clk)
  begin
    busy_s1 <= write_busy;
    busy_s2 <= busy_s1;
    ready_s1 <= dev_ready;
    ready_s2 <= ready_s1;
  end

  // straps; undriven pins are pulled low outside, so low is the default
  always_ff @(posedge link_clk)
  begin
    pins_s1 <= {wp, chip_select_bit2, chip_select_bit1, chip_select_bit0};
    pins_s2 <= pins_s1;
  end

  assign cs_s = pins_s2[2:0];
  assign wp_s = pins_s2[3];

  // clock and data lines, synchronised and filtered
  seei_filter u_scl_filt (
    .clk(link_clk),
    .rst_n(lrst_n),
    .din(scl_in),
    .dout(scl_f)
  );

  seei_filter u_sda_filt (
    .clk(link_clk),
    .rst_n(lrst_n),
    .din(sda_in),
    .dout(sda_f)
  );

  // previous filtered levels for edge detection
  always_ff @(posedge link_clk)
  begin
    if (!lrst_n)
    begin
      scl_d <= LINE_IDLE;
      sda_d <= LINE_IDLE;
    end
    else
    begin
      scl_d <= scl_f;
      sda_d <= sda_f;
    end
  end

  // framing: a data change while clock stays high
  assign start_ev = scl_f & scl_d & sda_d & ~sda_f;
  assign stop_ev = scl_f & scl_d & ~sda_d & sda_f;
  assign scl_rise = scl_f & ~scl_d;
  assign scl_fall = ~scl_f & scl_d;

  // busy until the system side has seen and finished the write
  assign link_busy = busy_s2 | wr_wait | ~ready_s2;

  // type code and compared select bits
  assign dev_match = (shreg[7:4] == TYPE_CODE) &&
    (((shreg[3:1] ^ cs_s) & CS_COMPARE) == 3'h0);

  assign mem_rd = mem[ptr];
  assign commit = stop_ev & wr_pend;

  // serial engine
  always_ff @(posedge link_clk)
  begin
    if (!lrst_n)
    begin
      state <= ST_IDLE;
      nxt <= ST_IDLE;
      bitcnt <= BITCNT_RST;
      shreg <= 8'h00;
      tx <= 8'h00;
      hi_bits <= 3'h0;
      ptr <= PTR_RST;
      wp_lat <= 1'b0;
      mack <= 1'b0;
      wr_pend <= 1'b0;
      wr_data <= 8'h00;
      sda_oe <= 1'b0;
    end
    else if (start_ev)
    begin
      // restart from address reception; stay deaf while writing
      bitcnt <= BITCNT_RST;
      sda_oe <= 1'b0;
      wr_pend <= 1'b0;
      state <= link_busy ? ST_IDLE : ST_DEV;
    end
    else if (stop_ev)
    begin
      // stop ends every command; a pending byte goes to memory
      state <= ST_IDLE;
      sda_oe <= 1'b0;
      wr_pend <= 1'b0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          sda_oe <= 1'b0;
        end
        ST_DEV, ST_MEM, ST_WDAT:
        begin
          if (scl_rise)
          begin
            shreg <= {shreg[6:0], sda_f};
            bitcnt <= bitcnt + 4'h1;
          end
          else if (scl_fall && bitcnt == BYTE_BITS)
          begin
            bitcnt <= BITCNT_RST;
            if (state == ST_DEV)
            begin
              if (dev_match)
              begin
                sda_oe <= 1'b1;
                state <= ST_ACK;
                hi_bits <= shreg[3:1] & ~CS_COMPARE;
                tx <= mem_rd;
                nxt <= shreg[0] ? ST_RDAT : ST_MEM;
              end
              else
                state <= ST_IDLE;
            end
            else if (state == ST_MEM)
            begin
              ptr <= {hi_bits, shreg};
              sda_oe <= 1'b1;
              state <= ST_ACK;
              nxt <= ST_WDAT;
            end
            else if (wp_lat)
              state <= ST_IDLE;
            else
            begin
              wr_data <= shreg;
              wr_pend <= 1'b1;
              sda_oe <= 1'b1;
              state <= ST_ACK;
              nxt <= ST_IDLE;
            end
          end
        end
        ST_ACK:
        begin
          // ninth clock ends at its falling edge
          if (scl_fall)
          begin
            bitcnt <= BITCNT_RST;
            state <= nxt;
            sda_oe <= (nxt == ST_RDAT) ? ~tx[7] : 1'b0;
            if (nxt == ST_WDAT)
              wp_lat <= wp_s;
          end
        end
        ST_RDAT:
        begin
          if (scl_rise)
            bitcnt <= bitcnt + 4'h1;
          else if (scl_fall)
          begin
            if (bitcnt == BYTE_BITS)
            begin
              sda_oe <= 1'b0;
              state <= ST_RACK;
              ptr <= ptr + 1'b1;
            end
            else
            begin
              tx <= {tx[6:0], 1'b0};
              sda_oe <= ~tx[6];
            end
          end
        end
        ST_RACK:
        begin
          if (scl_rise)
            mack <= ~sda_f;
          else if (scl_fall)
          begin
            bitcnt <= BITCNT_RST;
            if (mack)
            begin
              tx <= mem_rd;
              sda_oe <= ~mem_rd[7];
              state <= ST_RDAT;
            end
            else
              state <= ST_IDLE;
          end
        end
        default:
        begin
          state <= ST_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // data is only ever pulled low
  always_ff @(posedge link_clk)
  begin
    if (!lrst_n)
      sda_out <= 1'b0;
    else
      sda_out <= 1'b0;
  end

  // byte lands in the array on stop; no reset, contents survive
  always_ff @(posedge link_clk)
  begin
    if (commit)
      mem[ptr] <= wr_data;
  end

  // event to the system domain as a toggle
  always_ff @(posedge link_clk)
  begin
    if (!lrst_n)
      wr_tog <= 1'b0;
    else if (commit)
      wr_tog <= ~wr_tog;
  end

  // cover the crossing delay until busy arrives; set wins over clear
  always_ff @(posedge link_clk)
  begin
    if (!lrst_n)
      wr_wait <= 1'b0;
    else if (commit)
      wr_wait <= 1'b1;
    else if (busy_s2)
      wr_wait <= 1'b0;
  end

endmodule

// [hw/seei_pkg.sv]
// Purpose: constants and types shared by the serial eeprom slave front end
// Assumes: sys_clk at 125 MHz, link sampling clock with an 80 ns period
// Notes: every timing count is derived here from its time in its own unit
package seei_pkg;

  // fixed memory type code in the top nibble of the slave address
  localparam logic [3:0] TYPE_CODE = 4'ha;
  // 2 KiB array: 8 bits from the address byte, 3 from the slave address
  localparam int MEM_ADDR_W = 11;
  // which of the three extension bits compare against the select pins
  localparam logic [2:0] CS_COMPARE_DEF = 3'h0;

  // clock rates
  localparam int SYS_CLK_MHZ = 125;
  localparam int LINK_CLK_NS = 80;

  // internal_write_time, longest figure, in ms
  localparam int INTERNAL_WRITE_TIME_MS = 5;
  localparam int WR_CYC = INTERNAL_WRITE_TIME_MS * 1000 * SYS_CLK_MHZ;
  // powerup_ready_delay, longest figure, in ms
  localparam int POWERUP_READY_DELAY_MS = 1;
  localparam int PU_CYC = POWERUP_READY_DELAY_MS * 1000 * SYS_CLK_MHZ;

  // widest input noise pulse to suppress, in ns
  localparam int GLITCH_NS = 100;
  // samples that must agree before a level is accepted
  localparam int FILT_CYC = (GLITCH_NS + LINK_CLK_NS - 1) / LINK_CLK_NS + 1;

  // bits in a byte and the bit counter reset value
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] BITCNT_RST = 4'h0;

  // bus line idle level and pointer reset value
  localparam logic LINE_IDLE = 1'b1;
  localparam logic [MEM_ADDR_W-1:0] PTR_RST = 11'h000;

  // one-hot states of the serial engine
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_DEV = 7'h02,
    ST_MEM = 7'h04,
    ST_WDAT = 7'h08,
    ST_ACK = 7'h10,
    ST_RDAT = 7'h20,
    ST_RACK = 7'h40
  } seei_state_t;

endpackage

// [hw/seei_filter.sv]
// Purpose: two-flop synchroniser plus noise filter for one bus line
// Assumes: din is asynchronous to clk
// Notes: the output follows only after FILT samples agree
`timescale 1ns/1ps
module seei_filter
  import seei_pkg::*;
#(
  parameter int FILT = FILT_CYC,
  parameter logic RST_VAL = LINE_IDLE
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // line
  input wire logic din,
  output logic dout
);

  logic s1;
  logic s2;
  logic [3:0] cnt;

  // first flop feeds only the second
  always_ff @(posedge clk)
  begin
    s1 <= din;
    s2 <= s1;
  end

  // accept a new level only after it held for FILT samples
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt <= 4'h0;
      dout <= RST_VAL;
    end
    else if (s2 == dout)
      cnt <= 4'h0;
    else if (cnt == 4'(FILT - 1))
    begin
      cnt <= 4'h0;
      dout <= s2;
    end
    else
      cnt <= cnt + 4'h1;
  end

endmodule

// [hw/seei_timer.sv]
// Purpose: one-shot cycle timer with a registered busy flag
// Assumes: start is a single-cycle pulse in the clk domain
// Notes: RST_RUN makes the timer run straight out of reset
`timescale 1ns/1ps
module seei_timer
#(
  parameter int unsigned COUNT = 1000,
  parameter bit RST_RUN = 1'b0,
  parameter int CNT_W = $clog2(COUNT + 1)
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control and status
  input wire logic start,
  output logic busy
);

  logic [CNT_W-1:0] cnt;

  // count down from COUNT-1; busy drops on the COUNTth cycle
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt <= RST_RUN ? CNT_W'(COUNT - 1) : '0;
      busy <= RST_RUN;
    end
    else if (start)
    begin
      cnt <= CNT_W'(COUNT - 1);
      busy <= 1'b1;
    end
    else if (busy)
    begin
      if (cnt == '0)
        busy <= 1'b0;
      else
        cnt <= cnt - 1'b1;
    end
  end

endmodule

// [test/seei_props.sv]
// Purpose: port checks on the serial memory slave front end
// Assumes: counts match those set on the bound instance
// Notes: each domain is watched with its own clock and the shared reset
`timescale 1ns/1ps
module seei_props
#(
  parameter int unsigned WR_CYCLES = 200,
  parameter int unsigned PU_CYCLES = 100
)
(
  // clocks and reset
  input wire logic sys_clk,
  input wire logic link_clk,
  input wire logic resetn,
  // bus and status
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic write_busy,
  input wire logic dev_ready
);
  int unsigned bcnt;
  int unsigned pcnt;
  // cycles busy and cycles waiting for ready; counters keep long spans out of repetitions
  always_ff @(posedge sys_clk)
  begin
    bcnt <= (resetn && write_busy) ? bcnt + 1 : 0;
    pcnt <= (resetn && !dev_ready) ? pcnt + 1 : 0;
  end

  property p_low;
    @(posedge link_clk) disable iff (!resetn) sda_oe |-> sda_out == 1'h0;
  endproperty
  a_low: assert property (p_low)
    else $error("data line driven high");
  property p_edge;
    @(posedge link_clk) disable iff (!resetn) $changed(sda_oe) |-> !scl_in;
  endproperty
  a_edge: assert property (p_edge)
    else $error("data output moved while clock high");
  property p_rst;
    @(posedge sys_clk) !resetn |=> !write_busy && !dev_ready;
  endproperty
  a_rst: assert property (p_rst)
    else $error("status not cleared by reset");
  property p_hold;
    @(posedge sys_clk) disable iff (!resetn) dev_ready |=> dev_ready;
  endproperty
  a_hold: assert property (p_hold)
    else $error("ready dropped without reset");
  property p_ready;
    @(posedge sys_clk) disable iff (!resetn)
      $rose(dev_ready) |-> pcnt >= PU_CYCLES && pcnt <= PU_CYCLES + 3;
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready at wrong time after reset");
  property p_busy;
    @(posedge sys_clk) disable iff (!resetn)
      $fell(write_busy) |-> bcnt + 1 >= WR_CYCLES && bcnt <= WR_CYCLES + 1;
  endproperty
  a_busy: assert property (p_busy)
    else $error("write cycle length wrong");
  property p_quiet;
    @(posedge link_clk) disable iff (!resetn) write_busy |-> !sda_oe;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("data line driven during write cycle");
  property p_unready;
    @(posedge link_clk) disable iff (!resetn) !dev_ready |-> !sda_oe;
  endproperty
  a_unready: assert property (p_unready)
    else $error("data line driven before ready");
endmodule

bind seei_slave seei_props #(.WR_CYCLES(WR_CYCLES), .PU_CYCLES(PU_CYCLES)) u_props (
  .sys_clk(sys_clk), .link_clk(link_clk), .resetn(resetn), .scl_in(scl_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .write_busy(write_busy), .dev_ready(dev_ready));

// [test/seei_master.sv]
// Purpose: behavioural bus master driving clock and data
// Assumes: Q is a quarter bit in clk cycles, clock low at least 1.3 us in a bit, one Q (672 ns) before a repeated start
// Notes: data is released for a one and pulled up by the bench
`timescale 1ns/1ps
module seei_master
#(
  parameter int Q = 84
)
(
  // clock and resolved line
  input wire logic clk,
  input wire logic sda,
  // driven lines
  output logic scl,
  output logic sda_o
);
  // idle bus: both lines released
  initial
  begin
    scl = 1'h1;
    sda_o = 1'h1;
  end
  // waits n cycles, then steps just after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // start or repeated start; only the master makes the clock
  task automatic start;
    sda_o = 1'h1;
    tick(Q);
    scl = 1'h1;
    tick(Q);
    sda_o = 1'h0;
    tick(Q);
    scl = 1'h0;
  endtask
  // one bit: data changes only while clock low, sampled mid high
  task automatic bit_io(input logic b, output logic r);
    tick(Q);
    sda_o = b;
    tick(Q);
    scl = 1'h1;
    tick(Q);
    r = sda;
    tick(Q);
    scl = 1'h0;
  endtask
  // eight bits msb first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(ai, a);
  endtask
  // stop then bus-free gap before anything new
  task automatic stop;
    tick(Q);
    sda_o = 1'h0;
    tick(Q);
    scl = 1'h1;
    tick(Q);
    sda_o = 1'h1;
    tick(2 * Q);
  endtask
endmodule

// [test/seei_slave_bench.sv]
// Purpose: self-checking bench for the serial memory slave
// Assumes: write and power-up counts shortened for simulation
// Notes: a byte array model predicts every read byte
`timescale 1ns/1ps
module seei_slave_bench;
  import seei_pkg::*;
  localparam int WRC = 4000;
  localparam int PUC = 1000;
  logic sys_clk = 1'h0;
  logic link_clk = 1'h0;
  logic resetn = 1'h0;
  logic wp = 1'h0;
  logic [2:0] cs = 3'h0;
  logic scl, sda_m, sda_out, sda_oe, write_busy, dev_ready, a;
  logic [7:0] q;
  logic [7:0] mem [0:2047];
  logic [10:0] ptr;
  logic [7:0] wd;
  int n;
  logic [3:0] bad [2] = '{4'hb, 4'h2};
  integer seed = 32'h977c_7a1a;
  int mismatches = 0;
  int checked = 0;
  wire logic sda;
  // open-drain wire with pull-up
  assign sda = sda_m & (sda_oe ? sda_out : 1'h1);
  // clocks, link phase unrelated to the system clock
  always #4 sys_clk = ~sys_clk;
  always #40 link_clk = ~link_clk;

  seei_slave #(.WR_CYCLES(WRC), .PU_CYCLES(PUC)) u_seei_slave (
    .sys_clk(sys_clk), .resetn(resetn), .link_clk(link_clk), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_bit0(cs[0]), .chip_select_bit1(cs[1]),
    .chip_select_bit2(cs[2]), .wp(wp), .write_busy(write_busy), .dev_ready(dev_ready));
  seei_master #(.Q(84)) mst (.clk(sys_clk), .sda(sda), .scl(scl), .sda_o(sda_m));

  task automatic print_verdict;
    if (mismatches == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // compare one acknowledge or status bit
  task automatic chk_ack(input logic got, input logic exp);
    checked++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %0t ack %h exp %h", $time, got, exp);
      mismatches++;
    end
  endtask
  // compare one read byte
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %0t data %h exp %h", $time, got, exp);
      mismatches++;
    end
  endtask
  // send a byte, expecting ack low or a release
  task automatic sb(input logic [7:0] d, input logic e);
    mst.xfer(d, 1'h1, q, a);
    chk_ack(a, e);
  endtask
  // set pointer without a data byte
  task automatic seek(input logic [10:0] ad);
    mst.start();
    sb({TYPE_CODE, ad[10:8], 1'h0}, 1'h0);
    sb(ad[7:0], 1'h0);
    ptr = ad;
  endtask
  // read n bytes from the pointer, master releases the last ack
  task automatic rd(input int n);
    mst.start();
    sb({TYPE_CODE, ptr[10:8], 1'h1}, 1'h0);
    for (int i = 0; i < n; i++)
    begin
      mst.xfer(8'hff, i == n - 1, q, a);
      chk_byte(q, mem[ptr]);
      ptr = ptr + 11'h001;
    end
    mst.stop();
  endtask
  // byte write, then probe during and after the write cycle
  task automatic wr(input logic [10:0] ad, input logic [7:0] d);
    int i;
    cs = 3'($random(seed));
    seek(ad);
    sb(d, wp);
    mst.stop();
    chk_ack(write_busy, !wp);
    if (!wp)
    begin
      mem[ad] = d;
      mst.start();
      sb({TYPE_CODE, ad[10:8], 1'h0}, 1'h1);
      mst.stop();
      for (i = 0; i < WRC && write_busy; i++)
        @(posedge sys_clk);
      if (i == WRC)
      begin
        mismatches++;
        print_verdict();
      end
      #1;
      mst.start();
      sb({TYPE_CODE, ad[10:8], 1'h0}, 1'h0);
      mst.stop();
    end
  endtask

  // main sequence
  initial
  begin
    repeat (4) @(posedge link_clk);
    @(posedge sys_clk);
    #1;
    resetn = 1'h1;
    // a command opened before power-up ends stays unanswered
    mst.start();
    sb({TYPE_CODE, 4'h0}, 1'h1);
    mst.stop();
    chk_ack(dev_ready, 1'h1);
    // wrong type codes get no answer
    foreach (bad[i])
    begin
      mst.start();
      sb({bad[i], 4'h0}, 1'h1);
      mst.stop();
    end
    wr(11'h7ff, 8'($random(seed)));
    wr(11'h000, 8'($random(seed)));
    // read across the top of the array after a repeated start
    seek(11'h7ff);
    rd(2);
    // protected write is refused, and no write cycle starts
    wp = 1'h1;
    wr(11'h000, 8'($random(seed)));
    wp = 1'h0;
    // brown-out in a write cycle: status clears, pointer restarts at zero
    wd = 8'($random(seed));
    seek(11'h123);
    sb(wd, 1'h0);
    mst.stop();
    mem[11'h123] = wd;
    chk_ack(write_busy, 1'h1);
    resetn = 1'h0;
    repeat (4) @(posedge link_clk);
    @(posedge sys_clk);
    #1;
    chk_ack(write_busy, 1'h0);
    chk_ack(dev_ready, 1'h0);
    resetn = 1'h1;
    ptr = PTR_RST;
    for (n = 0; n < PUC + 8 && !dev_ready; n++)
      @(posedge sys_clk);
    if (n == PUC + 8)
    begin
      mismatches++;
      print_verdict();
    end
    #1;
    rd(1);
    print_verdict();
  end
endmodule
